/* core/evch_top.sv */
// Purpose: four event channels with two-wire asynchronous handshake
// Assumes: event_request_in pins asynchronous to clk
// Notes:   channel address decode is registered helper logic
// Notes:   an output command ends on the answer's rise; the answer must fall later
// Notes:   an unowned input channel still arms, so an early event is not lost
// Notes:   process side inputs come from logic on clk and pass no synchroniser
`include "evch_map.svh"
`timescale 1ns/1ps
`default_nettype none
module evch_top
(
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            rst_b,
	// four pin pairs
	// Handshake pins
	input  wire logic [`EVCH_NUM_CH-1:0]         event_request_in,
	output var  logic [`EVCH_NUM_CH-1:0]         event_ack_out,
	// Process side, one entry per channel
	input  wire evch_pkg::evch_proc_req_t        proc_req [`EVCH_NUM_CH],
	output var  evch_pkg::evch_proc_stat_t       proc_stat [`EVCH_NUM_CH],
	// Channel address lookup
	input  wire logic [31:0]                     chan_addr,
	output var  logic                            chan_hit_reg,
	output var  logic [1:0]                      chan_index_reg,
	output var  logic                            chan_is_out_reg,
	// Resource mode word placement
	input  wire logic [31:0]                     resource_block_base,
	input  wire logic [1:0]                      resource_sel,
	output var  logic [31:0]                     resource_addr_reg
);
	import evch_pkg::*;

	localparam int NCH = `EVCH_NUM_CH;

	// Decode a channel address into hit, index and direction
	function automatic logic [3:0] decode_addr(input logic [31:0] a);
		logic [31:0] off;
		off = a - `EVCH_ADDR_FIRST;
		if (a >= `EVCH_ADDR_FIRST && a <= `EVCH_ADDR_LAST && a[1:0] == 2'b00)
			return {1'b1, off[4:3], off[2]};
		else
			return 4'h0;
	endfunction

	// Synchroniser: three stages, change counts when last two agree
	// Only the agreed level is used, so a runt pulse is dropped
	logic [2:0] sync_reg  [NCH];
	logic [2:0] sync_next [NCH];
	logic [NCH-1:0] req_level_reg;
	logic [NCH-1:0] req_level_next;

	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			sync_next[i] = {sync_reg[i][1:0], event_request_in[i]};
			if (sync_reg[i][2] == sync_reg[i][1])
				req_level_next[i] = sync_reg[i][2];
			else
				req_level_next[i] = req_level_reg[i];
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			// Stages clear on reset so no false rise follows it
			for (int i = 0; i < NCH; i++)
				sync_reg[i] <= `EVCH_SYNC_RST;
			req_level_reg <= '0;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
				sync_reg[i] <= sync_next[i];
			req_level_reg <= req_level_next;
		end
	end

	// Channel handshake state
	evch_state_t      st_reg    [NCH];
	evch_state_t      st_next   [NCH];
	logic [NCH-1:0]   ack_reg, ack_next;
	logic [NCH-1:0]   mode_reg, mode_next;
	logic [NCH-1:0]   owner_reg, owner_next;
	logic [NCH-1:0]   prev_req_reg;
	evch_proc_stat_t  stat_next [NCH];
	logic [NCH-1:0]   prev_req_next;
	logic [NCH-1:0]   req_rise;
	logic [NCH-1:0]   req_gone;
	logic [NCH-1:0]   in_go;
	logic [NCH-1:0]   out_go;

	// Rise of a settled level against its previous sample
	function automatic logic level_rose(input logic now_lvl, input logic old_lvl);
		return now_lvl && !old_lvl;
	endfunction

	// Edges of the settled level and the start conditions
	always_comb
	begin
		prev_req_next = req_level_reg;
		for (int i = 0; i < NCH; i++)
		begin
			req_rise[i] = level_rose(req_level_reg[i], prev_req_reg[i]);
			req_gone[i] = !req_level_reg[i];
			in_go[i]    = owner_reg[i] && proc_req[i].proc_ready;
			// Answer must be low first
			// A stale answer from the last command would end the next one at once
			out_go[i]   = mode_reg[i] && owner_reg[i] && proc_req[i].proc_ready
				&& req_gone[i];
		end
	end

	always_comb
	begin
		for (int i = 0; i < NCH; i++)
		begin
			st_next[i]    = st_reg[i];
			ack_next[i]   = ack_reg[i];
			mode_next[i]  = mode_reg[i];
			owner_next[i] = owner_reg[i];
			stat_next[i]  = '0;
			if (!owner_reg[i] && proc_req[i].attach)
			begin
				owner_next[i] = 1'b1;
				// mode latched at attach only
				// Sampled once, so it cannot flip mid handshake
				mode_next[i]  = proc_req[i].output_mode;
			end
			// Owner lets go on attach drop only in idle; reset_chan frees it mid handshake
			else if (owner_reg[i] && !proc_req[i].attach && st_reg[i] == EVCH_IDLE)
				owner_next[i] = 1'b0;
			case (st_reg[i])
				EVCH_IDLE:
				begin
					ack_next[i] = 1'b0;
					if (!mode_reg[i] && req_rise[i])
						st_next[i] = EVCH_READY;
					else if (out_go[i])
					begin
						st_next[i]  = EVCH_DRIVE;
						ack_next[i] = 1'b1;
					end
				end

				EVCH_READY:
				begin
					if (in_go[i])
					begin
						ack_next[i] = 1'b1;
						stat_next[i].schedule = 1'b1;
						st_next[i] = EVCH_ACK;
					end
				end

				EVCH_ACK:
				begin
					if (req_gone[i])
					begin
						ack_next[i] = 1'b0;
						stat_next[i].done = 1'b1;
						st_next[i] = EVCH_IDLE;
					end
				end

				EVCH_DRIVE:
				begin
					// hardware answered; end command
					// Outgoing pin drops on the answer; the answer then falls on its own
					if (req_level_reg[i])
					begin
						ack_next[i] = 1'b0;
						stat_next[i].done = 1'b1;
						st_next[i] = EVCH_IDLE;
					end
				end

				default:
				begin
					st_next[i]  = EVCH_IDLE;
					ack_next[i] = 1'b0;
				end
			endcase
			// channel reset forces pin low
			// Outranks every state and frees the owner
			if (proc_req[i].reset_chan)
			begin
				st_next[i]    = EVCH_IDLE;
				ack_next[i]   = 1'b0;
				owner_next[i] = 1'b0;
			end
			stat_next[i].chan_ready = (st_next[i] == EVCH_READY);
			stat_next[i].busy       = owner_next[i];
		end
	end

	// Prevents a level held from the last cycle re-arming the channel
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < NCH; i++)
			begin
				st_reg[i]    <= EVCH_IDLE;
				proc_stat[i] <= '0;
			end
			ack_reg      <= `EVCH_ACK_RST;
			mode_reg     <= `EVCH_MODE_RST;
			owner_reg    <= '0;
			prev_req_reg <= '0;
		end
		else
		begin
			for (int i = 0; i < NCH; i++)
			begin
				st_reg[i]    <= st_next[i];
				proc_stat[i] <= stat_next[i];
			end
			ack_reg      <= ack_next;
			mode_reg     <= mode_next;
			owner_reg    <= owner_next;
			prev_req_reg <= prev_req_next;
		end
	end

	// Pin comes straight from its flip-flop
	assign event_ack_out = ack_reg;

	// Address decode and resource word placement
	logic [3:0]  dec;
	logic [31:0] res_next;
	logic        hit_next;
	logic [1:0]  index_next;
	logic        is_out_next;

	always_comb
	begin
		dec = decode_addr(chan_addr);
		// Misaligned or out of range gives no hit
		hit_next    = dec[3];
		index_next  = dec[2:1];
		is_out_next = dec[0];
		// two words per channel at block bottom
		// Base bits 1:0 ignored: the block is word aligned
		res_next = {resource_block_base[31:2], 2'b00}
			+ {27'h0, resource_sel, 3'h0};
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			chan_hit_reg      <= 1'b0;
			chan_index_reg    <= 2'h0;
			chan_is_out_reg   <= 1'b0;
			resource_addr_reg <= 32'h0;
		end
		else
		begin
			chan_hit_reg      <= hit_next;
			chan_index_reg    <= index_next;
			chan_is_out_reg   <= is_out_next;
			resource_addr_reg <= res_next;
		end
	end
endmodule
`default_nettype wire

/* core/evch_map.svh */
// Purpose: constants for the event channel handshake block
// Assumes: 32-bit word addresses, four channels
// Notes:   addresses are byte addresses of the reserved words
`ifndef EVCH_MAP_SVH
`define EVCH_MAP_SVH
`define EVCH_NUM_CH        4
`define EVCH_ADDR_FIRST    32'h80000020
`define EVCH_ADDR_LAST     32'h8000003C
`define EVCH_ADDR_WORDS    8
`define EVCH_RES_WORDS_CH  2
`define EVCH_ACK_RST       4'h0
`define EVCH_MODE_RST      4'h0
`define EVCH_SYNC_RST      3'h0
`endif

/* core/evch_pkg.sv */
// Purpose: types for the event channel handshake block
// Assumes: four channels
// Notes:   constants live in evch_map.svh
package evch_pkg;
	typedef enum logic [3:0]
	{
		EVCH_IDLE  = 4'h1,
		EVCH_READY = 4'h2,
		EVCH_ACK   = 4'h4,
		EVCH_DRIVE = 4'h8
	} evch_state_t;

	// Per-channel process side request
	typedef struct packed
	{
		logic attach;
		logic output_mode;
		logic proc_ready;
		logic reset_chan;
	} evch_proc_req_t;

	// Per-channel process side status
	typedef struct packed
	{
		logic chan_ready;
		logic schedule;
		logic done;
		logic busy;
	} evch_proc_stat_t;
endpackage

/* testbench/evch_assertions.sv */
// Purpose: port checks for evch_top
// Assumes: ch0 input, ch1-2 output
// Notes:   bound from tb
`include "evch_map.svh"
`timescale 1ns/1ps
`default_nettype none
module evch_assertions
(
	// Clock and reset
	input wire logic                      clk,
	input wire logic                      rst_b,
	// Pins
	input wire logic [3:0]                event_request_in,
	input wire logic [3:0]                event_ack_out,
	// Process side
	input wire evch_pkg::evch_proc_req_t  proc_req [`EVCH_NUM_CH],
	input wire evch_pkg::evch_proc_stat_t proc_stat [`EVCH_NUM_CH],
	// Lookups
	input wire logic [31:0]               chan_addr,
	input wire logic                      chan_hit_reg,
	input wire logic [1:0]                chan_index_reg,
	input wire logic                      chan_is_out_reg,
	input wire logic [31:0]               resource_block_base,
	input wire logic [1:0]                resource_sel,
	input wire logic [31:0]               resource_addr_reg
);
	import evch_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	ack_after_reset_a: assert property (!$past(rst_b) |-> event_ack_out == 4'h0)
		else $error("ack high after reset");
	chan_reset_a: assert property (proc_req[2].reset_chan |=> !event_ack_out[2])
		else $error("ack kept over channel reset");
	ack_cause_a: assert property ($rose(event_ack_out[1]) |->
		$past(proc_req[1].proc_ready) && $past(proc_req[1].attach))
		else $error("ack rose without ready process");
	in_sched_a: assert property ($rose(event_ack_out[0]) && !proc_req[0].output_mode
		|-> proc_stat[0].schedule) else $error("no schedule with ack");
	drop_after_a: assert property ($fell(event_ack_out[0]) && !$past(proc_req[0].reset_chan)
		|-> !event_request_in[0]) else $error("ack fell with request high");
	sync_delay_a: assert property ($rose(proc_stat[0].chan_ready)
		|-> $past(event_request_in[0], 3)) else $error("request seen too early");
	hold_ack_a: assert property (event_ack_out[2] && proc_req[2].output_mode &&
		!proc_req[2].reset_chan && !event_request_in[2] |=> event_ack_out[2])
		else $error("command dropped early");
	addr_hit_a: assert property (chan_addr[31:5] == 27'h4000001 && chan_addr[1:0] == 2'h0
		|=> chan_hit_reg && chan_index_reg == $past(chan_addr[4:3])
		&& chan_is_out_reg == $past(chan_addr[2])) else $error("bad channel decode");
	res_addr_a: assert property (##1 resource_addr_reg ==
		{$past(resource_block_base[31:2]), 2'h0} + 32'h8 * $past(resource_sel))
		else $error("bad resource word address");
	cover property (proc_stat[0].schedule);
	cover property (proc_stat[1].done);
	cover property (chan_hit_reg && chan_is_out_reg);
endmodule
`default_nettype wire

/* testbench/evch_partner.sv */
// Purpose: external event hardware
// Assumes: out_mode fixed during a handshake
// Notes:   go starts one input event
`timescale 1ns/1ps
`default_nettype none
module evch_partner
(
	// Clock
	input  wire logic       clk,
	// Control and pins
	input  wire logic [3:0] ack,
	input  wire logic [3:0] out_mode,
	input  wire logic [3:0] go,
	output var  logic [3:0] pin
);
	initial pin = 4'h0;
	for (genvar i = 0; i < 4; i++)
	begin : g_ch
		always @(posedge clk)
		begin
			if (out_mode[i] && ack[i])
			begin
				pin[i] <= 1'b1;
				do @(posedge clk); while (ack[i]);
				pin[i] <= 1'b0;
			end
			else if (!out_mode[i] && go[i])
			begin
				pin[i] <= 1'b1;
				do @(posedge clk); while (!ack[i]);
				pin[i] <= 1'b0;
				do @(posedge clk); while (ack[i]);
				repeat (2) @(posedge clk);
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/evch_tb.sv */
// Purpose: self-checking bench for evch_top
// Assumes: outputs read at edge, before updates land
// Notes:   ch0/3 input, ch1/2 output
`include "evch_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
	import evch_pkg::*;
	logic            clk = 1'b0;
	logic            rst_b = 1'b0;
	logic [3:0]      pin, ack, om = 4'h0, go = 4'h0;
	evch_proc_req_t  rq [4];
	evch_proc_stat_t st [4];
	logic [31:0]     addr = 32'h0, base = 32'h0, raddr;
	logic [1:0]      sel = 2'h0, idx;
	logic            hit, iso;
	int              errors = 0, check_count = 0, n;
	always #50 clk = ~clk;
	evch_top dut (.clk, .rst_b, .event_request_in(pin), .event_ack_out(ack),
		.proc_req(rq), .proc_stat(st), .chan_addr(addr), .chan_hit_reg(hit),
		.chan_index_reg(idx), .chan_is_out_reg(iso), .resource_block_base(base),
		.resource_sel(sel), .resource_addr_reg(raddr));
	evch_partner far (.clk, .ack, .out_mode(om), .go, .pin);
	task chk(input logic c, input string m);
		check_count++;
		if (c !== 1'b1)
		begin
			errors++;
			$display("mismatch %0t %s", $time, m);
		end
	endtask
	task end_of_test;
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	task t_in(input int c);
		rq[c] <= 4'h8;
		go[c] <= 1'b1;
		cyc(1);
		go[c] <= 1'b0;
		for (n = 0; n < 9 && st[c].chan_ready !== 1'b1; n++) cyc(1);
		chk(st[c].chan_ready === 1'b1 && ack[c] === 1'b0, "in ready");
		chk(st[c].busy === 1'b1, "in busy");
		rq[c] <= 4'hA;
		cyc(2);
		chk(ack === 4'h1 << c && st[c].schedule === 1'b1, "in ack");
		for (n = 0; n < 12 && st[c].done !== 1'b1; n++) cyc(1);
		chk(st[c].done === 1'b1 && ack[c] === 1'b0 && !pin[c], "in end");
		rq[c] <= 4'h0;
		cyc(4);
	endtask
	task t_out(input int c);
		rq[c] <= 4'hC;
		cyc(4);
		chk(ack[c] === 1'b0, "idle ack");
		rq[c] <= 4'hE;
		cyc(2);
		chk(ack[c] === 1'b1, "out ack");
		cyc(3);
		chk(ack[c] === 1'b1, "out hold");
		rq[c] <= 4'h1;
		cyc(2);
		chk(ack[c] === 1'b0, "chan reset");
		chk(st[c].busy === 1'b0, "reset frees");
		rq[c] <= 4'h0;
		om[c] <= 1'b1;
		cyc(1);
		rq[c] <= 4'hE;
		for (n = 0; n < 14 && st[c].done !== 1'b1; n++) cyc(1);
		chk(st[c].done === 1'b1 && ack[c] === 1'b0 && pin[c], "out end");
		rq[c] <= 4'h0;
		om[c] <= 1'b0;
		cyc(3);
	endtask
	task t_map;
		for (int k = 0; k < 9; k++)
		begin
			addr <= `EVCH_ADDR_FIRST + 32'h4 * k;
			base <= 32'h1234567F;
			sel <= k[1:0];
			cyc(2);
			chk(hit === (k < 8) && (k > 7 || {idx, iso} === k[2:0]), "decode");
			chk(raddr === 32'h1234567C + 32'h8 * k[1:0], "resource");
		end
	endtask
	initial
	begin
		foreach (rq[i]) rq[i] = 4'h0;
		cyc(12);
		rst_b <= 1'b1;
		cyc(2);
		chk(ack === 4'h0, "reset ack");
		t_in(0);
		t_in(3);
		t_out(1);
		t_out(2);
		t_map;
		end_of_test;
	end
	initial
	begin
		#400000;
		errors++;
		end_of_test;
	end
endmodule
bind evch_top evch_assertions u_chk (.clk, .rst_b, .event_request_in, .event_ack_out,
	.proc_req, .proc_stat, .chan_addr, .chan_hit_reg, .chan_index_reg, .chan_is_out_reg,
	.resource_block_base, .resource_sel, .resource_addr_reg);
`default_nettype wire
